// ==== src/bridge_window_params.svh ====
// Offsets, field positions, reset values for the memory window registers.
// Assumes byte addressing on a 32-bit register bus, one word per register.
`ifndef BRIDGE_WINDOW_PARAMS_SVH
`define BRIDGE_WINDOW_PARAMS_SVH

`define REG_ADDR_W     8
`define OFF_MEM_WIN    8'h20
`define OFF_PF_WIN     8'h24
`define OFF_PF_BOT_HI  8'h28
`define OFF_PF_TOP_HI  8'h2C

`define FIELD_W        12
`define BOT_FIELD_LSB  4
`define TOP_FIELD_LSB  20
`define FIELD_RST      12'h000
`define HI_WORD_RST    32'h00000000
`define RO_ZERO        4'h0
`define PF_IND_64      4'h1
`define LOW_ZERO       20'h00000
`define LOW_ONES       20'hFFFFF

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ==== src/bridge_window_pkg.sv ====
// Types shared by the memory window register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package bridge_window_pkg;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'h1,
		WR_RESP    = 2'h2
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_DATA = 2'h2
	} rd_state_t;

	typedef logic [1:0] resp_t;

endpackage

// ==== src/window_match.sv ====
// Inclusive range compare of one address against one window.
// Assumes base and limit are already expanded to full width.
`timescale 1ns/1ns
module window_match #(
	parameter int AW = 64
) (
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          reset_n,
	input  wire logic          ce,
	// Compare
	input  wire logic [AW-1:0] addr,
	input  wire logic [AW-1:0] base,
	input  wire logic [AW-1:0] limit,
	output logic               hit_ff
);

	logic nxt_hit;

	// Both ends count; base above limit never matches
	always_comb
	begin
		nxt_hit = (addr >= base) && (addr <= limit);
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			hit_ff <= 1'b0;
		else if (ce)
			hit_ff <= nxt_hit;
	end

endmodule // window_match

// ==== src/axil_read_port.sv ====
// AXI4-Lite read channel: takes an address, returns one registered word.
// Assumes the parent supplies the looked-up word for the current araddr.
`timescale 1ns/1ns
`include "bridge_window_params.svh"
module axil_read_port (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	// Read address and data channels
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output bridge_window_pkg::resp_t rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Lookup from the register file
	input  wire logic [31:0] rd_value,
	input  wire logic        rd_mapped
);

	bridge_window_pkg::rd_state_t state_ff;
	bridge_window_pkg::rd_state_t nxt_state;
	logic [31:0]                  data_ff;
	logic [31:0]                  nxt_data;
	bridge_window_pkg::resp_t     resp_ff;
	bridge_window_pkg::resp_t     nxt_resp;

	assign arready = (state_ff == bridge_window_pkg::RD_IDLE);
	assign rvalid  = (state_ff == bridge_window_pkg::RD_DATA);
	assign rdata   = data_ff;
	assign rresp   = resp_ff;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_data  = data_ff;
		nxt_resp  = resp_ff;
		case (state_ff)
			bridge_window_pkg::RD_IDLE:
			begin
				if (arvalid)
				begin
					nxt_data  = rd_value;
					nxt_resp  = rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
					nxt_state = bridge_window_pkg::RD_DATA;
				end
			end
			bridge_window_pkg::RD_DATA:
			begin
				if (rready)
					nxt_state = bridge_window_pkg::RD_IDLE;
			end
			default:
				nxt_state = bridge_window_pkg::RD_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_ff <= bridge_window_pkg::RD_IDLE;
			data_ff  <= 32'h00000000;
			resp_ff  <= `RESP_OKAY;
		end
		else if (ce)
		begin
			state_ff <= nxt_state;
			data_ff  <= nxt_data;
			resp_ff  <= nxt_resp;
		end
	end

endmodule // axil_read_port

// ==== src/bridge_memory_window_regs.sv ====
// Memory and prefetchable memory window registers with forwarding decode.
// Assumes an AXI4-Lite master, one clock, and a forwarding address input.
`timescale 1ns/1ns
`include "bridge_window_params.svh"
module bridge_memory_window_regs (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	input  wire logic                   ce,
	// AXI4-Lite write channels
	input  wire logic [`REG_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output bridge_window_pkg::resp_t    s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [`REG_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output bridge_window_pkg::resp_t    s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Forwarding decode
	input  wire logic [63:0]            fwd_addr,
	output logic                        mem_window_hit,
	output logic                        prefetch_window_hit
);

	bridge_window_pkg::wr_state_t wr_state_ff;
	bridge_window_pkg::wr_state_t nxt_wr_state;
	logic                         aw_got_ff;
	logic                         nxt_aw_got;
	logic                         w_got_ff;
	logic                         nxt_w_got;
	logic [`REG_ADDR_W-1:0]       wr_addr_ff;
	logic [`REG_ADDR_W-1:0]       nxt_wr_addr;
	logic [31:0]                  wr_data_ff;
	logic [31:0]                  nxt_wr_data;
	logic [3:0]                   wr_strb_ff;
	logic [3:0]                   nxt_wr_strb;
	bridge_window_pkg::resp_t     bresp_ff;
	bridge_window_pkg::resp_t     nxt_bresp;
	logic                         do_write;

	logic [`FIELD_W-1:0]          mem_bot_ff;
	logic [`FIELD_W-1:0]          nxt_mem_bot;
	logic [`FIELD_W-1:0]          mem_top_ff;
	logic [`FIELD_W-1:0]          nxt_mem_top;
	logic [`FIELD_W-1:0]          pf_bot_ff;
	logic [`FIELD_W-1:0]          nxt_pf_bot;
	logic [`FIELD_W-1:0]          pf_top_ff;
	logic [`FIELD_W-1:0]          nxt_pf_top;
	logic [31:0]                  pf_bot_hi_ff;
	logic [31:0]                  nxt_pf_bot_hi;
	logic [31:0]                  pf_top_hi_ff;
	logic [31:0]                  nxt_pf_top_hi;
	logic [31:0]                  merged;

	logic [63:0]                  mem_base_exp;
	logic [63:0]                  mem_limit_exp;
	logic [63:0]                  pf_base_exp;
	logic [63:0]                  pf_limit_exp;

	function automatic logic is_mapped(input logic [`REG_ADDR_W-1:0] a);
		logic [`REG_ADDR_W-1:0] w;
		w = {a[`REG_ADDR_W-1:2], 2'h0};
		is_mapped = (w == `OFF_MEM_WIN) || (w == `OFF_PF_WIN) ||
			(w == `OFF_PF_BOT_HI) || (w == `OFF_PF_TOP_HI);
	endfunction

	// Read-only nibbles are rebuilt here, never stored
	function automatic logic [31:0] reg_read(
		input logic [`REG_ADDR_W-1:0] a);
		logic [`REG_ADDR_W-1:0] w;
		w = {a[`REG_ADDR_W-1:2], 2'h0};
		case (w)
			`OFF_MEM_WIN:
				reg_read = {mem_top_ff, `RO_ZERO, mem_bot_ff, `RO_ZERO};
			`OFF_PF_WIN:
				reg_read = {pf_top_ff, `PF_IND_64, pf_bot_ff, `PF_IND_64};
			`OFF_PF_BOT_HI:
				reg_read = pf_bot_hi_ff;
			`OFF_PF_TOP_HI:
				reg_read = pf_top_hi_ff;
			default:
				reg_read = 32'h00000000;
		endcase
	endfunction

	function automatic logic [31:0] byte_merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		byte_merge = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				byte_merge[i*8 +: 8] = data[i*8 +: 8];
	endfunction

	// Write address and data accepted in either order
	assign s_axi_awready = (wr_state_ff == bridge_window_pkg::WR_COLLECT) &&
		!aw_got_ff;
	assign s_axi_wready  = (wr_state_ff == bridge_window_pkg::WR_COLLECT) &&
		!w_got_ff;
	assign s_axi_bvalid  = (wr_state_ff == bridge_window_pkg::WR_RESP);
	assign s_axi_bresp   = bresp_ff;

	always_comb
	begin
		nxt_wr_state = wr_state_ff;
		nxt_aw_got   = aw_got_ff;
		nxt_w_got    = w_got_ff;
		nxt_wr_addr  = wr_addr_ff;
		nxt_wr_data  = wr_data_ff;
		nxt_wr_strb  = wr_strb_ff;
		nxt_bresp    = bresp_ff;
		do_write     = 1'b0;
		case (wr_state_ff)
			bridge_window_pkg::WR_COLLECT:
			begin
				if (s_axi_awvalid && s_axi_awready)
				begin
					nxt_aw_got  = 1'b1;
					nxt_wr_addr = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready)
				begin
					nxt_w_got   = 1'b1;
					nxt_wr_data = s_axi_wdata;
					nxt_wr_strb = s_axi_wstrb;
				end
				// Commit one cycle after both halves are held
				if (aw_got_ff && w_got_ff)
				begin
					do_write     = 1'b1;
					nxt_aw_got   = 1'b0;
					nxt_w_got    = 1'b0;
					nxt_bresp    = is_mapped(wr_addr_ff) ? `RESP_OKAY :
						`RESP_SLVERR;
					nxt_wr_state = bridge_window_pkg::WR_RESP;
				end
			end
			bridge_window_pkg::WR_RESP:
			begin
				if (s_axi_bready)
					nxt_wr_state = bridge_window_pkg::WR_COLLECT;
			end
			default:
				nxt_wr_state = bridge_window_pkg::WR_COLLECT;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_state_ff <= bridge_window_pkg::WR_COLLECT;
			aw_got_ff   <= 1'b0;
			w_got_ff    <= 1'b0;
			wr_addr_ff  <= '0;
			wr_data_ff  <= 32'h00000000;
			wr_strb_ff  <= 4'h0;
			bresp_ff    <= `RESP_OKAY;
		end
		else if (ce)
		begin
			wr_state_ff <= nxt_wr_state;
			aw_got_ff   <= nxt_aw_got;
			w_got_ff    <= nxt_w_got;
			wr_addr_ff  <= nxt_wr_addr;
			wr_data_ff  <= nxt_wr_data;
			wr_strb_ff  <= nxt_wr_strb;
			bresp_ff    <= nxt_bresp;
		end
	end

	// Register file; unmapped writes change nothing
	always_comb
	begin
		nxt_mem_bot   = mem_bot_ff;
		nxt_mem_top   = mem_top_ff;
		nxt_pf_bot    = pf_bot_ff;
		nxt_pf_top    = pf_top_ff;
		nxt_pf_bot_hi = pf_bot_hi_ff;
		nxt_pf_top_hi = pf_top_hi_ff;
		merged = byte_merge(reg_read(wr_addr_ff), wr_data_ff, wr_strb_ff);
		if (do_write)
		begin
			case ({wr_addr_ff[`REG_ADDR_W-1:2], 2'h0})
				`OFF_MEM_WIN:
				begin
					nxt_mem_bot = merged[`BOT_FIELD_LSB +: `FIELD_W];
					nxt_mem_top = merged[`TOP_FIELD_LSB +: `FIELD_W];
				end
				`OFF_PF_WIN:
				begin
					nxt_pf_bot = merged[`BOT_FIELD_LSB +: `FIELD_W];
					nxt_pf_top = merged[`TOP_FIELD_LSB +: `FIELD_W];
				end
				`OFF_PF_BOT_HI:
					nxt_pf_bot_hi = merged;
				`OFF_PF_TOP_HI:
					nxt_pf_top_hi = merged;
				default:
					nxt_pf_top_hi = pf_top_hi_ff;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mem_bot_ff   <= `FIELD_RST;
			mem_top_ff   <= `FIELD_RST;
			pf_bot_ff    <= `FIELD_RST;
			pf_top_ff    <= `FIELD_RST;
			pf_bot_hi_ff <= `HI_WORD_RST;
			pf_top_hi_ff <= `HI_WORD_RST;
		end
		else if (ce)
		begin
			mem_bot_ff   <= nxt_mem_bot;
			mem_top_ff   <= nxt_mem_top;
			pf_bot_ff    <= nxt_pf_bot;
			pf_top_ff    <= nxt_pf_top;
			pf_bot_hi_ff <= nxt_pf_bot_hi;
			pf_top_hi_ff <= nxt_pf_top_hi;
		end
	end

	axil_read_port u_read (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.ce        (ce),
		.arvalid   (s_axi_arvalid),
		.arready   (s_axi_arready),
		.rdata     (s_axi_rdata),
		.rresp     (s_axi_rresp),
		.rvalid    (s_axi_rvalid),
		.rready    (s_axi_rready),
		.rd_value  (reg_read(s_axi_araddr)),
		.rd_mapped (is_mapped(s_axi_araddr))
	);

	// Memory window is 32-bit only: anything above 4 GB misses
	assign mem_base_exp  = {32'h00000000, mem_bot_ff, `LOW_ZERO};
	assign mem_limit_exp = {32'h00000000, mem_top_ff, `LOW_ONES};
	assign pf_base_exp   = {pf_bot_hi_ff, pf_bot_ff, `LOW_ZERO};
	assign pf_limit_exp  = {pf_top_hi_ff, pf_top_ff, `LOW_ONES};

	window_match #(.AW(64)) u_mem_match (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.ce      (ce),
		.addr    (fwd_addr),
		.base    (mem_base_exp),
		.limit   (mem_limit_exp),
		.hit_ff  (mem_window_hit)
	);

	window_match #(.AW(64)) u_pf_match (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.ce      (ce),
		.addr    (fwd_addr),
		.base    (pf_base_exp),
		.limit   (pf_limit_exp),
		.hit_ff  (prefetch_window_hit)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence s_full_write(logic [`REG_ADDR_W-1:0] off);
		ce && do_write && (wr_addr_ff == off) && (wr_strb_ff == 4'hF);
	endsequence

	a_ro_zero_nibbles:
	assert property ((reg_read(`OFF_MEM_WIN) & 32'h000F000F) == 32'h0)
	else $error("memory window read-only nibbles not zero");

	a_mem_base_field:
	assert property (s_full_write(`OFF_MEM_WIN) |=>
		mem_base_exp[31:0] == {$past(wr_data_ff[15:4]), 20'h00000})
	else $error("memory base not taken from bits 15:4");

	a_mem_limit_field:
	assert property (s_full_write(`OFF_MEM_WIN) |=>
		mem_limit_exp[31:0] == {$past(wr_data_ff[31:20]), 20'hFFFFF})
	else $error("memory limit not taken from bits 31:20");

	a_pf_indicator_read:
	assert property ((reg_read(`OFF_PF_WIN) & 32'h000F000F) == 32'h00010001)
	else $error("prefetch indicator does not read 0001");

	a_pf_base_field:
	assert property (s_full_write(`OFF_PF_WIN) |=>
		pf_base_exp[31:0] == {$past(wr_data_ff[15:4]), 20'h00000})
	else $error("prefetch base not taken from bits 15:4");

	a_pf_limit_field:
	assert property (s_full_write(`OFF_PF_WIN) |=>
		pf_limit_exp[31:0] == {$past(wr_data_ff[31:20]), 20'hFFFFF})
	else $error("prefetch limit not taken from bits 31:20");

	a_pf_base_high:
	assert property (s_full_write(`OFF_PF_BOT_HI) |=>
		pf_base_exp[63:32] == $past(wr_data_ff))
	else $error("prefetch base upper word not written");

	a_pf_limit_high:
	assert property (s_full_write(`OFF_PF_TOP_HI) |=>
		pf_limit_exp[63:32] == $past(wr_data_ff))
	else $error("prefetch limit upper word not written");

	a_mem_hit_range:
	assert property (ce |=> mem_window_hit == $past(fwd_addr[63:32] == 0 &&
		fwd_addr[31:20] >= mem_bot_ff && fwd_addr[31:20] <= mem_top_ff))
	else $error("memory window hit disagrees with range");

	a_limit_inclusive:
	assert property (ce && fwd_addr == pf_limit_exp &&
		pf_base_exp <= pf_limit_exp |=> prefetch_window_hit)
	else $error("address equal to limit did not hit");

	a_pf_high_hit:
	assert property (ce && fwd_addr[63:32] != 0 &&
		fwd_addr >= pf_base_exp && fwd_addr <= pf_limit_exp
		|=> prefetch_window_hit)
	else $error("address above 4 GB inside window did not hit");

endmodule // bridge_memory_window_regs

// ==== test/pci_agent_model.sv ====
// Memory transaction source standing on the far side of the window decode.
// Assumes the bridge samples fwd_addr on every enabled clock edge.
`timescale 1ns/1ns
module pci_agent_model (
	// Clock
	input  wire logic        sys_clk,
	// Decode
	output logic [63:0]      fwd_addr,
	input  wire logic        mem_window_hit,
	input  wire logic        prefetch_window_hit
);
	initial fwd_addr = 64'h0000000000000000;

	// One address held long enough for the registered hit to settle
	task automatic probe(input logic [63:0] a, output logic mh,
		output logic ph);
		@(posedge sys_clk);
		fwd_addr <= a;
		repeat (3) @(posedge sys_clk);
		mh = mem_window_hit;
		ph = prefetch_window_hit;
		// Address phase over: show the inverse, never the stale value
		fwd_addr <= ~a;
	endtask
endmodule // pci_agent_model

// ==== test/bridge_memory_window_regs_tb_top.sv ====
// Self-checking bench for the memory window register bank.
// Assumes the AXI4-Lite slave answers without a fixed latency.
`timescale 1ns/1ns
`include "bridge_window_params.svh"
module bridge_memory_window_regs_tb_top;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [3:0]  s;
		logic [31:0] rd;
		logic [1:0]  rsp;
	} reg_row_t;
	typedef struct packed {
		logic [63:0] a;
		logic        mh;
		logic        ph;
	} dec_row_t;

	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0]  wstrb = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] rdata;
	bridge_window_pkg::resp_t bresp, rresp;
	logic [63:0] fwd_addr;
	logic        mem_hit, pf_hit;
	int          num_errors = 0;
	int          check_count = 0;
	// Rows are cumulative: partial writes merge with the earlier value of the same register
	reg_row_t    regs [7] = '{
		'{8'h20, 32'hFFFFFFFF, 4'hF, 32'hFFF0FFF0, 2'h0},
		'{8'h20, 32'h12345678, 4'h1, 32'hFFF0FF70, 2'h0},
		'{8'h24, 32'hFFFFFFFF, 4'hF, 32'hFFF1FFF1, 2'h0},
		'{8'h24, 32'h00000000, 4'hF, 32'h00010001, 2'h0},
		'{8'h28, 32'hA5A5A5A5, 4'hF, 32'hA5A5A5A5, 2'h0},
		'{8'h2C, 32'h0000005A, 4'h3, 32'h0000005A, 2'h0},
		'{8'h30, 32'hFFFFFFFF, 4'hF, 32'h00000000, 2'h2}};
	// Boundaries of 0x10000000..0x123FFFFF and 0x1_10000000..0x2_200FFFFF
	dec_row_t    decs [9] = '{
		'{64'h000000000FFFFFFF, 1'b0, 1'b0},
		'{64'h0000000010000000, 1'b1, 1'b0},
		'{64'h00000000123FFFFF, 1'b1, 1'b0},
		'{64'h0000000012400000, 1'b0, 1'b0},
		'{64'h0000000110000000, 1'b0, 1'b1},
		'{64'h000000010FFFFFFF, 1'b0, 1'b0},
		'{64'h00000002200FFFFF, 1'b0, 1'b1},
		'{64'h0000000220100000, 1'b0, 1'b0},
		'{64'h0000000110000000, 1'b0, 1'b1}};

	bridge_memory_window_regs i_bridge_memory_window_regs (
		.sys_clk(sys_clk), .reset_n(reset_n), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .fwd_addr(fwd_addr),
		.mem_window_hit(mem_hit), .prefetch_window_hit(pf_hit));

	pci_agent_model i_pci_agent_model (
		.sys_clk(sys_clk), .fwd_addr(fwd_addr),
		.mem_window_hit(mem_hit), .prefetch_window_hit(pf_hit));

	initial
	begin
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Address and data offered together, each released once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		#(50 * 20000);
		num_errors++;
		test_done();
	end

	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		logic        mh, ph;
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		foreach (regs[i])
		begin
			axi_write(regs[i].a, regs[i].d, regs[i].s, r);
			check("bresp", r, regs[i].rsp);
			axi_read(regs[i].a, d, r);
			check("rdata", d, regs[i].rd);
			check("rresp", r, regs[i].rsp);
		end
		$display("test register rows done");
		// Windows for the decode rows; read-only nibbles written as F
		axi_write(`OFF_MEM_WIN, 32'h123F100F, 4'hF, r);
		axi_write(`OFF_PF_WIN, 32'h200F100F, 4'hF, r);
		axi_write(`OFF_PF_BOT_HI, 32'h00000001, 4'hF, r);
		axi_write(`OFF_PF_TOP_HI, 32'h00000002, 4'hF, r);
		foreach (decs[i])
		begin
			i_pci_agent_model.probe(decs[i].a, mh, ph);
			check("mem_window_hit", mh, decs[i].mh);
			check("prefetch_window_hit", ph, decs[i].ph);
		end
		$display("test window decode done");
		// Reversed window never hits, top below bottom
		axi_write(`OFF_MEM_WIN, 32'h10001230, 4'hF, r);
		i_pci_agent_model.probe(64'h0000000011000000, mh, ph);
		check("mem_window_hit", mh, 1'b0);
		$display("test reversed window done");
		// Enable low must freeze the decode output
		ce <= 1'b0;
		i_pci_agent_model.probe(64'h0000000110000000, mh, ph);
		check("frozen pf hit", ph, 1'b0);
		ce <= 1'b1;
		i_pci_agent_model.probe(64'h0000000110000000, mh, ph);
		check("thawed pf hit", ph, 1'b1);
		$display("test clock enable done");
		// Second reset in mid-run brings every field back
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		axi_read(`OFF_MEM_WIN, d, r);
		check("mem reset", d, 32'h00000000);
		axi_read(`OFF_PF_WIN, d, r);
		check("pf reset", d, 32'h00010001);
		axi_read(`OFF_PF_BOT_HI, d, r);
		check("pf bottom high reset", d, 32'h00000000);
		axi_read(`OFF_PF_TOP_HI, d, r);
		check("pf top high reset", d, 32'h00000000);
		$display("test reset values done");
		test_done();
	end
endmodule // bridge_memory_window_regs_tb_top
